// ---- rtl/ulfc_regs.vh ----
// Register map, field positions, reset values and codes for the UART line/FIFO control block
`ifndef ULFC_REGS_VH
`define ULFC_REGS_VH

// Register word indices on the Avalon-MM slave
`define ULFC_IDX_DATA     3'h0
`define ULFC_IDX_IEN      3'h1
`define ULFC_IDX_ISR_FS   3'h2
`define ULFC_IDX_LFMT     3'h3
`define ULFC_IDX_MOC      3'h4
`define ULFC_IDX_MSTAT    3'h5
`define ULFC_IDX_EFR      3'h6

// Field positions
`define ULFC_FS_EN        0
`define ULFC_FS_RXRST     1
`define ULFC_FS_TXRST     2
`define ULFC_FS_DMA       3
`define ULFC_LF_STOP      2
`define ULFC_LF_PEN       3
`define ULFC_LF_EVEN      4
`define ULFC_LF_FORCE     5
`define ULFC_LF_BRK       6
`define ULFC_LF_DLAB      7
`define ULFC_MC_DTR       0
`define ULFC_MC_RTS       1
`define ULFC_MC_OUT1      2
`define ULFC_MC_OUT2      3
`define ULFC_MC_LOOP      4
`define ULFC_EFR_EN       4

// Reset values
`define ULFC_RST_LFMT     8'h00
`define ULFC_RST_MOC      8'h00
`define ULFC_RST_IEN      8'h00
`define ULFC_RST_EFR      8'h00
`define ULFC_RST_DIV      8'h00
`define ULFC_RST_TRIG     2'h0

// Interrupt identification codes, bits 3:1
`define ULFC_ID_LSR       3'h3
`define ULFC_ID_RXTO      3'h6
`define ULFC_ID_RXRDY     3'h2
`define ULFC_ID_TXRDY     3'h1
`define ULFC_ID_MSR       3'h0

// Trigger levels in characters
`define ULFC_TRIG_0       5'h01
`define ULFC_TRIG_1       5'h04
`define ULFC_TRIG_2       5'h08
`define ULFC_TRIG_3       5'h0E

`endif

// ---- rtl/ulfc_top.v ----
// UART line format, FIFO setup, interrupt status and modem control logic
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// [RQ1] Bits 3:1 of interrupt status encode highest pending source by fixed priority.
// [RQ2] With enhanced enable, bit 4 flags Xoff or special match; cleared as documented.
// [RQ3] With enhanced enable, bit 5 flags that flow signal was deasserted.
// [RQ4] Interrupt status bits 7:6 read one with FIFOs enabled, else zero.
// [RQ5] FIFO setup bit 0 enables FIFOs; other bits take effect only with it.
// [RQ6] FIFO setup bit 1 pulses a receive FIFO reset, self-clearing.
// [RQ7] FIFO setup bit 2 pulses a transmit FIFO reset, self-clearing.
// [RQ8] FIFO setup bit 3 is ignored; host writes zero.
// [RQ9] Transmit ready when level falls below trigger or FIFO empties.
// [RQ10] Receive ready when receive level reaches the selected trigger.
// [RQ11] Trigger selects map 00,01,10,11 to 1,4,8,14 characters; reset 00.
// [RQ12] Line format bits 1:0 give five to eight data bits.
// [RQ13] Stop bit 2 gives one, one and half for five bits, else two.
// [RQ14] Line format bit 3 enables parity generation and checking.
// [RQ15] Line format bit 4 picks odd (0) or even (1) parity.
// [RQ16] Line format bit 5 forces parity: one if bit 4 low, else zero.
// [RQ17] Line format bit 6 holds the serial output low as break.
// [RQ18] Line format bit 7 maps low two addresses onto divisor bytes.
// [RQ19] Modem bits 0,1 hold inverted ready and send signals, loopback only.
// [RQ20] Modem bit 2 drives no pin; feeds ring indicator in loopback.
// [RQ21] Modem bit 3 enables interrupt output drive in bus mode zero.
// [RQ22] Modem bit 3 feeds carrier detect status in loopback.
// [RQ23] Modem bit 4 selects internal loopback; zero at reset.
// [RQ24] In loopback clear-to-send follows send bit, data-set-ready follows ready.
// [RQ25] Hardware reset clears FIFO setup, line format and modem bits.
`include "ulfc_regs.vh"

module ulfc_top #(
   parameter LVL_W = 5
) (
   // Clock, reset, enable
   input  wire             clk_in,
   input  wire             rst_b_in,
   input  wire             ce_in,
   // Avalon-MM slave
   input  wire [2:0]       avs_address_in,
   input  wire             avs_read_in,
   input  wire             avs_write_in,
   input  wire [7:0]       avs_writedata_in,
   output reg  [7:0]       avs_readdata_out,
   output reg              avs_waitrequest_out,
   // Bus mode strap: 0 selects tri-state interrupt, 1 open active-low
   input  wire             bus_mode_in,
   // Events and levels from the data path
   input  wire [LVL_W-1:0] rx_level_in,
   input  wire [LVL_W-1:0] tx_level_in,
   input  wire             lsr_irq_in,
   input  wire             rx_timeout_in,
   input  wire             msr_irq_in,
   input  wire             xoff_det_in,
   input  wire             xon_det_in,
   input  wire             special_det_in,
   input  wire             rx_char_in,
   input  wire             flow_deassert_in,
   input  wire [7:0]       rx_data_in,
   input  wire             tx_serial_in,
   // Modem inputs, active low
   input  wire             cts_n_in,
   input  wire             dsr_n_in,
   input  wire             ri_n_in,
   input  wire             cd_n_in,
   // Data path control
   output reg              fifo_en_out,
   output reg              rx_fifo_reset_out,
   output reg              tx_fifo_reset_out,
   output reg  [1:0]       rx_trig_sel_out,
   output reg  [1:0]       tx_trig_sel_out,
   output reg              data_wr_out,
   output reg  [7:0]       data_out,
   output reg              data_rd_out,
   output reg  [15:0]      divisor_out,
   output reg  [7:0]       line_format_out,
   output reg  [7:0]       modem_output_control_out,
   output reg              serial_out,
   // Interrupt pin
   output reg              irq_out,
   output reg              irq_oe_out
);

   ////////////////////////////////////////////////////////////////////////////
   function [LVL_W-1:0] trig_count;
      input [1:0] sel;
      begin
         // [RQ11] Trigger level map
         case (sel)
            2'h0:    trig_count = `ULFC_TRIG_0;
            2'h1:    trig_count = `ULFC_TRIG_1;
            2'h2:    trig_count = `ULFC_TRIG_2;
            2'h3:    trig_count = `ULFC_TRIG_3;
            default: trig_count = `ULFC_TRIG_0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Data register hit; the divisor latch shadows it while selected
   function data_hit;
      input [2:0] adr;
      input       dl;
      begin
         data_hit = (adr == `ULFC_IDX_DATA) & ~dl;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   reg  [7:0]       ien_r;
   reg  [7:0]       efr_r;
   reg              txrdy_r;
   reg              xoff_r;
   reg              spec_r;
   reg              flow_r;
   reg  [LVL_W-1:0] tx_lvl_q_r;
   reg              shown_tx_r;

   wire             acc_rd;
   wire             acc_wr;
   wire             efr_en;
   wire             dlab;
   wire             loop;
   wire [LVL_W-1:0] rx_trig;
   wire [LVL_W-1:0] tx_trig;
   wire             tx_fall;
   wire             tx_empty;
   wire             rxrdy;
   wire             isr_rd;
   wire             thr_wr;

   // Access completes at the edge where waitrequest is seen low
   assign acc_rd   = avs_read_in & ~avs_waitrequest_out;
   assign acc_wr   = avs_write_in & ~avs_waitrequest_out;
   assign efr_en   = efr_r[`ULFC_EFR_EN];
   // [RQ18] Divisor latch select
   assign dlab     = line_format_out[`ULFC_LF_DLAB];
   // [RQ23] Loopback select
   assign loop     = modem_output_control_out[`ULFC_MC_LOOP];
   // Without FIFOs one character is the threshold
   assign rx_trig  = fifo_en_out ? trig_count(rx_trig_sel_out) : `ULFC_TRIG_0;
   assign tx_trig  = fifo_en_out ? trig_count(tx_trig_sel_out) : `ULFC_TRIG_0;
   // [RQ9] Falling below trigger, or emptying after a short reload
   assign tx_fall  = (tx_level_in < tx_trig) & (tx_lvl_q_r >= tx_trig);
   // A FIFO that stays empty raises nothing; only the drop to zero counts
   assign tx_empty = (tx_level_in == {LVL_W{1'b0}}) & (tx_lvl_q_r != {LVL_W{1'b0}});
   // [RQ10] Receive trigger reached
   assign rxrdy    = ien_r[0] & (rx_level_in >= rx_trig);
   assign isr_rd   = acc_rd & (avs_address_in == `ULFC_IDX_ISR_FS);
   assign thr_wr   = acc_wr & data_hit(avs_address_in, dlab);

   ////////////////////////////////////////////////////////////////////////////
   reg  [2:0] id_nxt;
   reg        pend_nxt;
   reg        shown_tx_nxt;
   reg  [7:0] isr_nxt;
   reg  [7:0] mstat_nxt;
   reg  [7:0] rd_nxt;

   always @* begin
      // [RQ1] Fixed priority encoder
      pend_nxt     = 1'b1;
      id_nxt       = `ULFC_ID_MSR;
      shown_tx_nxt = 1'b0;
      if (ien_r[2] & lsr_irq_in) begin
         id_nxt = `ULFC_ID_LSR;
      end else if (ien_r[0] & rx_timeout_in) begin
         id_nxt = `ULFC_ID_RXTO;
      end else if (rxrdy) begin
         id_nxt = `ULFC_ID_RXRDY;
      end else if (ien_r[1] & txrdy_r) begin
         id_nxt       = `ULFC_ID_TXRDY;
         shown_tx_nxt = 1'b1;
      end else if (ien_r[3] & msr_irq_in) begin
         id_nxt = `ULFC_ID_MSR;
      end else if (xoff_r | spec_r | flow_r) begin
         id_nxt = `ULFC_ID_MSR;
      end else begin
         pend_nxt = 1'b0;
      end
      // [RQ4] FIFO enable status
      isr_nxt = {{2{fifo_en_out}}, flow_r, xoff_r | spec_r, id_nxt, ~pend_nxt};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Modem status as seen by software
   always @* begin
      // [RQ24] Loopback status mirrors the modem control bits
      if (loop) begin
         // [RQ19] Ready and send bits reach software only here
         // [RQ20] Ring indicator and [RQ22] carrier detect from bits 2, 3
         mstat_nxt = {modem_output_control_out[`ULFC_MC_OUT2],
                      modem_output_control_out[`ULFC_MC_OUT1],
                      modem_output_control_out[`ULFC_MC_DTR],
                      modem_output_control_out[`ULFC_MC_RTS], 4'h0};
      end else begin
         mstat_nxt = {~cd_n_in, ~ri_n_in, ~dsr_n_in, ~cts_n_in, 4'h0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data is latched at the taking edge, one cycle before the clearing edge,
   // so only transmit ready is cleared by the state that its own read reported
   always @* begin
      case (avs_address_in)
         `ULFC_IDX_DATA:   rd_nxt = dlab ? divisor_out[7:0] : rx_data_in;
         `ULFC_IDX_IEN:    rd_nxt = dlab ? divisor_out[15:8] : ien_r;
         `ULFC_IDX_ISR_FS: rd_nxt = isr_nxt;
         `ULFC_IDX_LFMT:   rd_nxt = line_format_out;
         `ULFC_IDX_MOC:    rd_nxt = modem_output_control_out;
         `ULFC_IDX_MSTAT:  rd_nxt = mstat_nxt;
         `ULFC_IDX_EFR:    rd_nxt = efr_r;
         default:          rd_nxt = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle per access keeps read data registered
   // With ce_in low the wait state simply stretches; the master must keep waiting
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 8'h00;
         shown_tx_r          <= 1'b0;
         data_rd_out         <= 1'b0;
      end else if (ce_in) begin
         data_rd_out <= acc_rd & data_hit(avs_address_in, dlab);
         if ((avs_read_in | avs_write_in) & avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            if (avs_read_in) begin
               avs_readdata_out <= rd_nxt;
               shown_tx_r       <= shown_tx_nxt;
            end
         end else begin
            avs_waitrequest_out <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         // [RQ25] Everything clears on hardware reset
         fifo_en_out              <= 1'b0;
         rx_fifo_reset_out        <= 1'b0;
         tx_fifo_reset_out        <= 1'b0;
         rx_trig_sel_out          <= `ULFC_RST_TRIG;
         tx_trig_sel_out          <= `ULFC_RST_TRIG;
         line_format_out          <= `ULFC_RST_LFMT;
         modem_output_control_out <= `ULFC_RST_MOC;
         ien_r                    <= `ULFC_RST_IEN;
         efr_r                    <= `ULFC_RST_EFR;
         divisor_out              <= {`ULFC_RST_DIV, `ULFC_RST_DIV};
         data_wr_out              <= 1'b0;
         data_out                 <= 8'h00;
      end else if (ce_in) begin
         // [RQ6] [RQ7] Reset strobes last one cycle then self-clear
         rx_fifo_reset_out <= 1'b0;
         tx_fifo_reset_out <= 1'b0;
         data_wr_out       <= thr_wr;
         if (thr_wr) begin
            data_out <= avs_writedata_in;
         end
         if (acc_wr) begin
            case (avs_address_in)
               `ULFC_IDX_DATA: begin
                  if (dlab) begin
                     divisor_out[7:0] <= avs_writedata_in;
                  end
               end
               `ULFC_IDX_IEN: begin
                  if (dlab) begin
                     divisor_out[15:8] <= avs_writedata_in;
                  end else begin
                     ien_r <= avs_writedata_in;
                  end
               end
               `ULFC_IDX_ISR_FS: begin
                  // [RQ5] Bit 0 gates the rest of the write
                  fifo_en_out <= avs_writedata_in[`ULFC_FS_EN];
                  // [RQ8] Bit 3 deliberately unused
                  if (avs_writedata_in[`ULFC_FS_EN]) begin
                     // [RQ6] Receive FIFO pointer reset
                     rx_fifo_reset_out <= avs_writedata_in[`ULFC_FS_RXRST];
                     // [RQ7] Transmit FIFO pointer reset
                     tx_fifo_reset_out <= avs_writedata_in[`ULFC_FS_TXRST];
                     // [RQ10] Receive trigger select
                     rx_trig_sel_out   <= avs_writedata_in[7:6];
                     // [RQ9] Transmit select needs enhanced enable first
                     if (efr_en) begin
                        tx_trig_sel_out <= avs_writedata_in[5:4];
                     end
                  end
               end
               `ULFC_IDX_LFMT:  line_format_out          <= avs_writedata_in;
               `ULFC_IDX_MOC:   modem_output_control_out <= avs_writedata_in;
               `ULFC_IDX_EFR:   efr_r                    <= avs_writedata_in;
               default: begin
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky interrupt sources; a set in the clearing cycle wins
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         txrdy_r    <= 1'b0;
         xoff_r     <= 1'b0;
         spec_r     <= 1'b0;
         flow_r     <= 1'b0;
         tx_lvl_q_r <= {LVL_W{1'b0}};
      end else if (ce_in) begin
         tx_lvl_q_r <= tx_level_in;
         // [RQ9] Transmit ready, cleared by status read or data write
         if (tx_fall | tx_empty) begin
            txrdy_r <= 1'b1;
         end else if (thr_wr | (isr_rd & shown_tx_r)) begin
            txrdy_r <= 1'b0;
         end
         // [RQ2] Xoff match: status read or Xon clears
         if (efr_en & ien_r[5] & xoff_det_in) begin
            xoff_r <= 1'b1;
         end else if (isr_rd | xon_det_in | ~efr_en) begin
            xoff_r <= 1'b0;
         end
         // [RQ2] Special match: status read or next character clears
         if (efr_en & ien_r[5] & special_det_in) begin
            spec_r <= 1'b1;
         end else if (isr_rd | rx_char_in | ~efr_en) begin
            spec_r <= 1'b0;
         end
         // [RQ3] Flow signal deasserted
         if (efr_en & flow_deassert_in) begin
            flow_r <= 1'b1;
         end else if (isr_rd | ~efr_en) begin
            flow_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial line and interrupt pin
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         serial_out <= 1'b1;
         irq_out    <= 1'b0;
         irq_oe_out <= 1'b0;
      end else if (ce_in) begin
         // [RQ17] Break forces the line low
         serial_out <= tx_serial_in & ~line_format_out[`ULFC_LF_BRK];
         if (bus_mode_in) begin
            // Open active-low request; bit 3 is kept zero by the host here
            irq_out    <= ~pend_nxt;
            irq_oe_out <= pend_nxt;
         end else begin
            // [RQ21] Bit 3 enables the active-high drive
            irq_out    <= pend_nxt;
            irq_oe_out <= modem_output_control_out[`ULFC_MC_OUT2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line format decode is done by the framer from line_format_out:
   // [RQ12] bits 1:0 word length 5..8, [RQ13] bit 2 stop length,
   // [RQ14] bit 3 parity on, [RQ15] bit 4 sense, [RQ16] bit 5 forced value.
   // Keeping one copy avoids the framer and this block disagreeing.
   // [RQ19] Modem bits 0,1 leave only through loopback status, no pin.
   // [RQ23] Loopback select is modem bit 4.

endmodule

// ---- verif/ulfc_host_model.sv ----
// Avalon-MM host model that drives the register port of the block
`timescale 1ns/1ps
module ulfc_host_model (
   // Bus towards the block
   input  wire       clk_in,
   output reg  [2:0] bus_addr_out,
   output reg        bus_rd_out,
   output reg        bus_wr_out,
   output reg  [7:0] bus_wd_out,
   input  wire [7:0] bus_rdata_in,
   input  wire       bus_wait_in
);
   initial begin
      bus_addr_out = 3'h0;
      bus_rd_out = 1'b0;
      bus_wr_out = 1'b0;
      bus_wd_out = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Called just after a rising edge; holds the request until waitrequest is seen low
   task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      bus_addr_out <= a;
      bus_wd_out <= d;
      bus_wr_out <= wr;
      bus_rd_out <= !wr;
      do @(posedge clk_in); while (bus_wait_in !== 1'b0);
      q = bus_rdata_in;
      bus_rd_out <= 1'b0;
      bus_wr_out <= 1'b0;
      // Idle edge so a following call never re-drives the strobe in the same step
      @(posedge clk_in);
   endtask
endmodule

// ---- verif/ulfc_chk_monitor.sv ----
// Concurrent checks on the ports of the line format and FIFO control block
`timescale 1ns/1ps
module ulfc_chk (
   // Clock, reset and bus
   input wire        clk_in,
   input wire        rst_b_in,
   input wire [2:0]  avs_address_in,
   input wire        avs_read_in,
   input wire        avs_write_in,
   input wire [7:0]  avs_writedata_in,
   input wire [7:0]  avs_readdata_out,
   input wire        avs_waitrequest_out,
   // Bus mode strap and control outputs
   input wire        bus_mode_in,
   input wire        fifo_en_out,
   input wire        rx_fifo_reset_out,
   input wire        tx_fifo_reset_out,
   input wire [1:0]  rx_trig_sel_out,
   input wire [15:0] divisor_out,
   input wire        data_wr_out,
   input wire [7:0]  line_format_out,
   input wire [7:0]  modem_output_control_out,
   input wire        serial_out,
   input wire        irq_oe_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   wire wr_done = avs_write_in && !avs_waitrequest_out;
   wire rd_take = avs_read_in && avs_waitrequest_out;
   wire [7:0] wd = avs_writedata_in;
   wire [2:0] ad = avs_address_in;
   ////////////////////////////////////////////////////////////////////////////////
   fifo_enable_a: assert property (wr_done && ad == 3'h2
      |=> fifo_en_out == $past(wd[0])) else $error("fifo enable not taken");
   rx_flush_a: assert property (wr_done && ad == 3'h2 && wd[0] && wd[1]
      |=> rx_fifo_reset_out ##1 !rx_fifo_reset_out) else $error("rx flush pulse wrong");
   tx_flush_a: assert property (wr_done && ad == 3'h2 && wd[0] && wd[2]
      |=> tx_fifo_reset_out ##1 !tx_fifo_reset_out) else $error("tx flush pulse wrong");
   gated_setup_a: assert property (wr_done && ad == 3'h2 && !wd[0]
      |=> !rx_fifo_reset_out && !tx_fifo_reset_out && $stable(rx_trig_sel_out))
      else $error("setup bits acted without enable");
   rx_trig_a: assert property (wr_done && ad == 3'h2 && wd[0]
      |=> rx_trig_sel_out == $past(wd[7:6])) else $error("rx trigger not taken");
   fifo_status_a: assert property (rd_take && ad == 3'h2
      |=> avs_readdata_out[7:6] == {2{fifo_en_out}}) else $error("status bits 7:6 wrong");
   line_fmt_a: assert property (wr_done && ad == 3'h3
      |=> line_format_out == $past(wd)) else $error("line format not taken");
   break_low_a: assert property (line_format_out[6] |=> !serial_out)
      else $error("serial output not held low in break");
   divisor_low_a: assert property (wr_done && ad == 3'h0 && line_format_out[7]
      |=> divisor_out[7:0] == $past(wd) && !data_wr_out) else $error("divisor low wrong");
   loop_status_a: assert property (rd_take && ad == 3'h5 && modem_output_control_out[4]
      |=> avs_readdata_out[7:4] == $past({modem_output_control_out[3:2],
      modem_output_control_out[0], modem_output_control_out[1]})) else $error("loop status");
   irq_drive_a: assert property (!bus_mode_in && $past(!bus_mode_in)
      |-> irq_oe_out == $past(modem_output_control_out[3])) else $error("irq drive wrong");
endmodule
bind ulfc_top ulfc_chk u_chk (.clk_in, .rst_b_in, .avs_address_in, .avs_read_in,
   .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .bus_mode_in,
   .fifo_en_out, .rx_fifo_reset_out, .tx_fifo_reset_out, .rx_trig_sel_out, .divisor_out,
   .data_wr_out, .line_format_out, .modem_output_control_out, .serial_out, .irq_oe_out);

// ---- verif/tb_top.sv ----
// Self-checking bench for the line format, FIFO setup and modem control block
`timescale 1ns/1ps
module tb_top;
   logic clk_in = 1'b0, rst_b_in = 1'b0, bus_mode_in = 1'b0, tx_serial_in = 1'b1;
   logic lsr_irq_in = 1'b0, msr_irq_in = 1'b0, irq_out;
   logic [1:0] ev = 2'h0;
   logic [3:0] mdm_n = 4'hF;
   logic [4:0] rx_level_in = 5'h00, tx_level_in = 5'h00;
   logic [7:0] rx_data_in = 8'h00, q, mc;
   logic [2:0] avs_address_in;
   logic avs_read_in, avs_write_in, avs_waitrequest_out, fifo_en_out, serial_out, irq_oe_out;
   logic [7:0] avs_writedata_in, avs_readdata_out, line_format_out, data_out;
   logic [1:0] rx_trig_sel_out, tx_trig_sel_out;
   logic [15:0] divisor_out;
   int err_total = 0, checks = 0;
   logic [7:0] lf_tab [6] = '{8'h03, 8'h07, 8'h0B, 8'h1A, 8'h39, 8'h04};
   logic [4:0] trig_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
   always #2.5 clk_in = ~clk_in;
   ulfc_top DUT (.clk_in, .rst_b_in, .ce_in(1'b1), .avs_address_in, .avs_read_in,
      .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .bus_mode_in,
      .rx_level_in, .tx_level_in, .lsr_irq_in, .rx_timeout_in(1'b0), .msr_irq_in,
      .xoff_det_in(ev[0]), .xon_det_in(1'b0), .special_det_in(1'b0), .rx_char_in(1'b0),
      .flow_deassert_in(ev[1]), .rx_data_in, .tx_serial_in, .cts_n_in(mdm_n[0]),
      .dsr_n_in(mdm_n[1]), .ri_n_in(mdm_n[2]), .cd_n_in(mdm_n[3]), .fifo_en_out,
      .rx_fifo_reset_out(), .tx_fifo_reset_out(), .rx_trig_sel_out, .tx_trig_sel_out,
      .data_wr_out(), .data_out, .data_rd_out(), .divisor_out, .line_format_out,
      .modem_output_control_out(), .serial_out, .irq_out, .irq_oe_out);
   ulfc_host_model host (.clk_in, .bus_addr_out(avs_address_in), .bus_rd_out(avs_read_in),
      .bus_wr_out(avs_write_in), .bus_wd_out(avs_writedata_in),
      .bus_rdata_in(avs_readdata_out), .bus_wait_in(avs_waitrequest_out));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] e, input string nm);
      host.xfer(1'b0, a, 8'h00, q);
      chk(nm, q, e);
   endtask
   task automatic pls(input logic [1:0] m);
      ev <= m;
      @(posedge clk_in);
      ev <= 2'h0;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Whole run needs a few hundred cycles; this bound only catches a hung bus
   initial begin
      #100000;
      err_total++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      rc(3'h3, 8'h00, "lfmt_rst");
      rc(3'h4, 8'h00, "moc_rst");
      rc(3'h2, 8'h01, "status_rst");
      foreach (lf_tab[i]) begin
         wr(3'h3, lf_tab[i]);
         rc(3'h3, lf_tab[i], "lfmt");
         chk("lfmt_out", line_format_out, lf_tab[i]);
      end
      wr(3'h3, 8'h40);
      repeat (2) @(posedge clk_in);
      chk("break", serial_out, 1'b0);
      wr(3'h3, 8'h80);
      repeat (2) @(posedge clk_in);
      chk("idle", serial_out, 1'b1);
      wr(3'h0, 8'h34);
      wr(3'h1, 8'h12);
      rc(3'h1, 8'h12, "div_hi");
      chk("divisor", divisor_out, 16'h1234);
      wr(3'h3, 8'h00);
      rx_data_in <= 8'hA5;
      rc(3'h0, 8'hA5, "rx_data");
      wr(3'h0, 8'h5A);
      chk("tx_data", data_out, 8'h5A);
      $display("test format done");
      wr(3'h1, 8'h01);
      for (int k = 0; k < 4; k++) begin
         // Enable bit always set with the trigger bits
         wr(3'h2, {k[1:0], 6'h01});
         chk("rx_trig", rx_trig_sel_out, k[1:0]);
         rx_level_in <= trig_tab[k] - 5'h01;
         rc(3'h2, 8'hC1, "below_trig");
         rx_level_in <= trig_tab[k];
         rc(3'h2, 8'hC4, "at_trig");
      end
      wr(3'h2, 8'h06);
      chk("fifo_off", fifo_en_out, 1'b0);
      chk("trig_kept", rx_trig_sel_out, 2'h3);
      rc(3'h2, 8'h04, "nofifo");
      // Legacy DMA bit kept zero while both FIFOs are flushed
      wr(3'h2, 8'h07);
      rx_level_in <= 5'h01;
      tx_level_in <= 5'h02;
      lsr_irq_in <= 1'b1;
      wr(3'h1, 8'h0F);
      rc(3'h2, 8'hC6, "lsr");
      lsr_irq_in <= 1'b0;
      tx_level_in <= 5'h00;
      rc(3'h2, 8'hC4, "rxrdy");
      rx_level_in <= 5'h00;
      msr_irq_in <= 1'b1;
      rc(3'h2, 8'hC2, "txrdy");
      rc(3'h2, 8'hC0, "msr");
      chk("irq_level", irq_out, 1'b1);
      msr_irq_in <= 1'b0;
      $display("test fifo done");
      // Enhanced enable set before the next setup write
      wr(3'h6, 8'h10);
      wr(3'h2, 8'h31);
      chk("tx_trig", tx_trig_sel_out, 2'h3);
      wr(3'h1, 8'h20);
      pls(2'h1);
      rc(3'h2, 8'hD0, "xoff");
      rc(3'h2, 8'hC1, "xoff_clr");
      pls(2'h2);
      host.xfer(1'b0, 3'h2, 8'h00, q);
      chk("flow", q[5], 1'b1);
      wr(3'h6, 8'h00);
      pls(2'h1);
      rc(3'h2, 8'hC1, "xoff_off");
      wr(3'h7, 8'hFF);
      rc(3'h7, 8'h00, "unmapped");
      $display("test events done");
      mdm_n <= 4'h0;
      rc(3'h5, 8'hF0, "modem_pins");
      for (int k = 0; k < 4; k++) begin
         mc = 8'h10 | (8'h01 << k);
         wr(3'h4, mc);
         rc(3'h5, {mc[3], mc[2], mc[0], mc[1], 4'h0}, "loop");
      end
      wr(3'h4, 8'h08);
      repeat (2) @(posedge clk_in);
      chk("irq_oe_on", irq_oe_out, 1'b1);
      wr(3'h4, 8'h00);
      repeat (2) @(posedge clk_in);
      chk("irq_oe_off", irq_oe_out, 1'b0);
      bus_mode_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      chk("irq_idle_m1", irq_out, 1'b1);
      chk("irq_oe_m1", irq_oe_out, 1'b0);
      $display("test modem done");
      wr(3'h3, 8'h1B);
      wr(3'h2, 8'h01);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      rc(3'h3, 8'h00, "lfmt_rst2");
      chk("fifo_rst2", fifo_en_out, 1'b0);
      $display("test reset done");
      complete_run();
   end
endmodule
